// File: pips_phase2_sequencer.sv
// phase 2 identification stream sequencer, top level
`timescale 1ns/1ps
`default_nettype none
module pips_phase2_sequencer #(
	parameter int ASYNC_CYC = pips_pkg::ASYNC_PERIOD_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic mode8_in,
	input wire logic async_in,
	input wire logic sync_pulse_in,
	input wire logic extended_init_data_enable_in,
	input wire logic selftest_done_in,
	input wire logic [7:0] maker_code_field_in,
	input wire logic [1:0] axis_dir_in,
	input wire logic [1:0] range_sel_in,
	input wire logic [7:0] sensor_info_in,
	input wire logic [7:0] product_rev_in,
	input wire logic [3:0] device_config_six_in,
	input wire logic [6:0] julian_year_in,
	input wire logic [3:0] julian_month_in,
	input wire logic [4:0] julian_day_in,
	input wire logic [31:0] serial_in,
	input wire logic [9:0] raw_offset_in,
	input wire logic [9:0] average_test_deflection_in,
	input wire logic [3:0] device_config_one_in,
	input wire logic frame_ready_in,
	output logic frame_valid_out,
	output logic [9:0] frame_word_out,
	output logic busy_out,
	output logic phase3_out
);
	// refuse periods the 24-bit pacing counter cannot serve
	if (ASYNC_CYC < 2 || ASYNC_CYC > 24'hffffff) begin : g_async_check
		$error("async period out of range");
	end
	typedef enum logic [1:0] {PIPS_IDLE, PIPS_WAIT, PIPS_EMIT,
		PIPS_DONE} pips_state_type;
	pips_state_type state_reg;
	pips_frame_if fr();
	logic [23:0] tick_cnt_reg;
	logic tick;
	logic [5:0] field_reg;
	logic [4:0] rep_reg;
	logic half_reg;
	logic kind_reg;
	logic [4:0] k_val;
	logic [5:0] nfields;
	logic [3:0] nib;
	logic [3:0] axis_nib;
	logic [3:0] range_nib;
	logic st_zero;
	logic [1:0] half_val;
	logic [6:0] hidx;
	logic [9:0] word;
	logic last_slot;
	logic bout_valid;
	logic [9:0] bout_word;
	// ----------------------------------------
	// pacing: sync pulse or fixed period
	// ----------------------------------------
	assign tick = async_in ? (tick_cnt_reg == 24'(ASYNC_CYC - 1))
		: sync_pulse_in; // see RULE15
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) tick_cnt_reg <= 24'h0;
		else if (ce_in) begin
			if (state_reg == PIPS_IDLE || tick) tick_cnt_reg <= 24'h0;
			else tick_cnt_reg <= tick_cnt_reg + 24'h1;
		end
	end
	// ----------------------------------------
	// repetition count and field total
	// ----------------------------------------
	always_comb begin
		if (mode8_in) begin
			k_val = async_in ? pips_pkg::K8_ASYNC : pips_pkg::K8_SYNC; // see RULE8 see RULE9
			nfields = pips_pkg::FIELDS8;
		end else begin
			k_val = async_in ? pips_pkg::K10_ASYNC : pips_pkg::K10_SYNC; // see RULE2
			nfields = pips_pkg::FIELDS10;
		end
	end
	// ----------------------------------------
	// nibble content per field index (0 = D1)
	// ----------------------------------------
	always_comb begin
		case (axis_dir_in) // see RULE13
			2'h0: axis_nib = 4'h0;
			2'h1: axis_nib = 4'h4;
			2'h2: axis_nib = 4'h8;
			default: axis_nib = 4'hc;
		endcase
		case (range_sel_in) // see RULE14
			2'h0: range_nib = pips_pkg::RANGE_60;
			2'h1: range_nib = pips_pkg::RANGE_120;
			2'h2: range_nib = pips_pkg::RANGE_240;
			default: range_nib = pips_pkg::RANGE_480;
		endcase
	end
	assign st_zero = !extended_init_data_enable_in || !selftest_done_in; // see RULE4 see RULE6
	always_comb begin
		nib = pips_pkg::ZERO_NIB;
		case (field_reg)
			6'd0: nib = pips_pkg::PROTO_REV;
			6'd1: nib = mode8_in ? pips_pkg::BLOCKS8[7:4] : pips_pkg::BLOCKS10[7:4];
			6'd2: nib = mode8_in ? pips_pkg::BLOCKS8[3:0] : pips_pkg::BLOCKS10[3:0]; // see RULE10
			6'd3: nib = maker_code_field_in[7:4];
			6'd4: nib = maker_code_field_in[3:0];
			6'd5: nib = pips_pkg::SENSOR_TYPE[7:4];
			6'd6: nib = pips_pkg::SENSOR_TYPE[3:0]; // see RULE12
			6'd7: nib = axis_nib;
			6'd8: nib = range_nib;
			6'd9: nib = sensor_info_in[7:4];
			6'd10: nib = sensor_info_in[3:0];
			6'd11: nib = product_rev_in[7:4];
			6'd12: nib = product_rev_in[3:0];
			6'd13: nib = device_config_six_in;
			6'd14: nib = julian_year_in[6:3]; // see RULE3
			6'd15: nib = {julian_year_in[2:0], julian_month_in[3]};
			6'd16: nib = {julian_month_in[2:0], julian_day_in[4]};
			6'd17: nib = julian_day_in[3:0];
			6'd18, 6'd19, 6'd20, 6'd21, 6'd22, 6'd23, 6'd24, 6'd25:
				nib = serial_in[5'(31 - 4 * (field_reg - 6'd18)) -: 4];
			6'd26: nib = st_zero ? pips_pkg::ZERO_NIB : raw_offset_in[3:0]; // see RULE5
			6'd27: nib = st_zero ? pips_pkg::ZERO_NIB : raw_offset_in[7:4];
			6'd28: nib = st_zero ? pips_pkg::ZERO_NIB
				: {average_test_deflection_in[1:0], raw_offset_in[9:8]};
			6'd29: nib = st_zero ? pips_pkg::ZERO_NIB
				: average_test_deflection_in[5:2];
			6'd30: nib = st_zero ? pips_pkg::ZERO_NIB
				: average_test_deflection_in[9:6];
			6'd31: nib = extended_init_data_enable_in ? device_config_one_in
				: pips_pkg::ZERO_NIB; // see RULE4
			default: nib = pips_pkg::ZERO_NIB;
		endcase
	end
	// ----------------------------------------
	// frame word: id or data, 10-bit or half-nibble
	// ----------------------------------------
	assign hidx = {field_reg, half_reg};
	assign half_val = half_reg ? nib[1:0] : nib[3:2]; // see RULE7 see RULE11
	always_comb begin
		if (mode8_in) begin
			if (kind_reg == pips_pkg::PIPS_ID)
				word = {3'h0, hidx}; // page in [6:1], half address in [0]
			else word = {8'h00, half_val};
		end else begin
			if (kind_reg == pips_pkg::PIPS_ID) word = {6'h00, field_reg[3:0]};
			else word = {6'h00, nib};
		end
	end
	assign last_slot = (kind_reg == pips_pkg::PIPS_DATA) && (rep_reg == k_val - 5'h1)
		&& (!mode8_in || half_reg) && (field_reg == nfields - 6'h1);
	// ----------------------------------------
	// sequencer state: one frame per pacing tick
	// ----------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= PIPS_IDLE;
			field_reg <= 6'h0;
			rep_reg <= 5'h0;
			half_reg <= 1'b0;
			kind_reg <= pips_pkg::PIPS_ID;
		end else if (ce_in) begin
			case (state_reg)
				PIPS_IDLE: begin
					if (start_in) begin
						state_reg <= PIPS_WAIT;
						field_reg <= 6'h0;
						rep_reg <= 5'h0;
						half_reg <= 1'b0;
						kind_reg <= pips_pkg::PIPS_ID;
					end
				end
				PIPS_WAIT: begin
					if (tick) state_reg <= PIPS_EMIT; // see RULE15
				end
				PIPS_EMIT: begin
					if (fr.ready) begin
						state_reg <= last_slot ? PIPS_DONE : PIPS_WAIT;
						if (kind_reg == pips_pkg::PIPS_ID) kind_reg <= pips_pkg::PIPS_DATA; // see RULE1
						else begin
							kind_reg <= pips_pkg::PIPS_ID;
							if (rep_reg != k_val - 5'h1) rep_reg <= rep_reg + 5'h1;
							else begin
								rep_reg <= 5'h0;
								if (mode8_in && !half_reg) half_reg <= 1'b1;
								else begin
									half_reg <= 1'b0;
									field_reg <= field_reg + 6'h1;
								end
							end
						end
					end
				end
				PIPS_DONE: begin
					if (start_in) state_reg <= PIPS_IDLE;
				end
				default: state_reg <= PIPS_IDLE;
			endcase
		end
	end
	assign fr.valid = (state_reg == PIPS_EMIT);
	assign fr.word = word;
	pips_skid_buffer #(.WIDTH(10)) u_buf (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.up(fr.dst),
		.out_valid_out(bout_valid),
		.out_word_out(bout_word),
		.out_ready_in(frame_ready_in && !(frame_valid_out && !frame_ready_in))
	);
	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_valid_out <= 1'b0;
			frame_word_out <= 10'h000;
			busy_out <= 1'b0;
			phase3_out <= 1'b0;
		end else if (ce_in) begin
			if (!frame_valid_out || frame_ready_in) begin
				frame_valid_out <= bout_valid && frame_ready_in;
				frame_word_out <= bout_word;
			end
			busy_out <= (state_reg == PIPS_WAIT) || (state_reg == PIPS_EMIT);
			// hand over only once the last word has left the output stage
			phase3_out <= (state_reg == PIPS_DONE) && !bout_valid
				&& !frame_valid_out; // see RULE15
		end
	end
endmodule : pips_phase2_sequencer
`default_nettype wire

// File: pips_pkg.sv
// constants and types shared by the phase 2 sequencer
// Function
// RULE1 - each field sent k times, id first
// RULE2 - 10-bit k: async 8, sync 4
// RULE3 - D15..D18 carry Julian date, year first
// RULE4 - D27..D32 zero unless extended data set
// RULE5 - offset and self-test packed into D27..D31
// RULE6 - zeros when self-test results not ready
// RULE7 - 8-bit splits nibbles, half address, page
// RULE8 - 8-bit async k 16, 576 frames
// RULE9 - 8-bit sync k 8, 288 frames
// RULE10 - block count halves 00,10,00,00
// RULE11 - protocol revision halves 01 then 00
// RULE12 - sensor type halves 00,00,00,01
// RULE13 - axis code 00,01,10 to 0000,0100,1000
// RULE14 - range 0111,1000,1001,1010 for 60..480g
// RULE15 - one frame per sync or period, then phase 3
package pips_pkg;
	// ----------------------------------------
	// timing and counts
	// ----------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int ASYNC_PERIOD_US = 228;
	localparam int ASYNC_PERIOD_CYC = ASYNC_PERIOD_US * CLK_MHZ;
	localparam logic [4:0] K10_ASYNC = 5'h08;
	localparam logic [4:0] K10_SYNC = 5'h04;
	localparam logic [4:0] K8_ASYNC = 5'h10;
	localparam logic [4:0] K8_SYNC = 5'h08;
	localparam logic [5:0] FIELDS10 = 6'h20;
	localparam logic [5:0] FIELDS8 = 6'h09;
	// ----------------------------------------
	// field encodings
	// ----------------------------------------
	localparam logic [3:0] PROTO_REV = 4'h4;
	localparam logic [7:0] BLOCKS10 = 8'h20;
	// block count 20h, sent as the halves 00,10,00,00
	localparam logic [7:0] BLOCKS8 = 8'h20;
	localparam logic [7:0] SENSOR_TYPE = 8'h01;
	localparam logic [3:0] DEV1_FIELD = 4'h2;
	localparam logic [3:0] RANGE_60 = 4'h7;
	localparam logic [3:0] RANGE_120 = 4'h8;
	localparam logic [3:0] RANGE_240 = 4'h9;
	localparam logic [3:0] RANGE_480 = 4'ha;
	localparam logic [3:0] ZERO_NIB = 4'h0;
	typedef enum logic [0:0] {PIPS_ID, PIPS_DATA} pips_kind_type;
endpackage : pips_pkg

// File: pips_frame_if.sv
// carrier between the sequencer and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface pips_frame_if;
	logic valid;
	logic ready;
	logic [9:0] word;
	modport src (output valid, output word, input ready);
	modport dst (input valid, input word, output ready);
endinterface : pips_frame_if
`default_nettype wire

// File: pips_skid_buffer.sv
// two-entry buffer between sequencer and frame transmitter
`timescale 1ns/1ps
`default_nettype none
module pips_skid_buffer #(
	parameter int WIDTH = 10
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	pips_frame_if.dst up,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_word_out,
	input wire logic out_ready_in
);
	// refuse a buffer with no data bits
	if (WIDTH < 1) begin : g_width_check
		$error("width too small");
	end
	logic [WIDTH-1:0] mem_reg [2];
	logic wp_reg;
	logic rp_reg;
	logic [1:0] cnt_reg;
	logic push;
	logic pop;
	assign up.ready = (cnt_reg != 2'h2);
	assign push = up.valid && up.ready;
	assign pop = (cnt_reg != 2'h0) && out_ready_in;
	assign out_valid_out = (cnt_reg != 2'h0);
	assign out_word_out = mem_reg[rp_reg];
	// storage and pointers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end else if (ce_in) begin
			if (push) begin
				mem_reg[wp_reg] <= up.word;
				wp_reg <= ~wp_reg;
			end
			if (pop) rp_reg <= ~rp_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : pips_skid_buffer
`default_nettype wire

// File: pips_monitor.sv
// port checks for the phase 2 sequencer
`timescale 1ns/1ps
`default_nettype none
module pips_monitor #(
	parameter int ASYNC_CYC = pips_pkg::ASYNC_PERIOD_CYC
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic mode8_in,
	input wire logic async_in,
	input wire logic sync_pulse_in,
	input wire logic frame_ready_in,
	input wire logic frame_valid_out,
	input wire logic [9:0] frame_word_out,
	input wire logic busy_out,
	input wire logic phase3_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// cycles spent waiting for the next paced frame
	logic [15:0] wait_reg;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in)
			wait_reg <= 16'h0000;
		else if (frame_valid_out || !busy_out)
			wait_reg <= 16'h0000;
		else
			wait_reg <= wait_reg + 16'h0001;
	end
	chk_reset_idle: assert property ($fell(rst_in) |->
		!frame_valid_out && !busy_out && !phase3_out) else $error("not idle");
	chk_valid_holds: assert property (frame_valid_out &&
		!frame_ready_in |=> frame_valid_out) else $error("valid dropped");
	chk_word_holds: assert property (frame_valid_out &&
		!frame_ready_in |=> $stable(frame_word_out)) else $error("word moved");
	chk_start_busy: assert property ($rose(start_in) && !busy_out &&
		!phase3_out |-> ##[1:3] busy_out) else $error("no start");
	chk_sync_answer: assert property (busy_out && !async_in &&
		sync_pulse_in && !frame_valid_out |-> ##[1:20] frame_valid_out)
		else $error("tick not answered");
	chk_async_pace: assert property (async_in && !phase3_out |->
		wait_reg <= ASYNC_CYC + 12) else $error("period missed");
	chk_half_narrow: assert property (mode8_in && frame_valid_out |->
		frame_word_out[9:7] == 3'h0) else $error("wide half word");
	chk_phase3_stops: assert property (phase3_out && !start_in &&
		!frame_valid_out |=> !frame_valid_out) else $error("frame after end");
endmodule : pips_monitor
bind pips_phase2_sequencer pips_monitor #(.ASYNC_CYC(ASYNC_CYC)) mon (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.start_in(start_in),
	.mode8_in(mode8_in),
	.async_in(async_in),
	.sync_pulse_in(sync_pulse_in),
	.frame_ready_in(frame_ready_in),
	.frame_valid_out(frame_valid_out),
	.frame_word_out(frame_word_out),
	.busy_out(busy_out),
	.phase3_out(phase3_out)
);
`default_nettype wire

// File: pips_receiver_model.sv
// receiving end of the frame stream, optionally stalling
`timescale 1ns/1ps
`default_nettype none
module pips_receiver_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic stall_in,
	input wire logic valid_in,
	input wire logic [9:0] word_in,
	output logic ready_out,
	output logic got_out,
	output logic [9:0] got_word_out
);
	// take a word on valid and ready, then choose the next ready level
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b0;
			got_out <= 1'b0;
			got_word_out <= 10'h000;
		end else begin
			got_out <= valid_in && ready_out;
			got_word_out <= word_in;
			ready_out <= !stall_in || ($urandom % 4 != 0);
		end
	end
endmodule : pips_receiver_model
`default_nettype wire

// File: pips_phase2_sequencer_tb.sv
// self-checking bench for the phase 2 sequencer
`timescale 1ns/1ps
`default_nettype none
module pips_phase2_sequencer_tb;
	logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, start_in = 1'b0;
	logic mode8_in = 1'b0, async_in = 1'b0, sync_pulse_in = 1'b0;
	logic extended_init_data_enable_in = 1'b0, selftest_done_in = 1'b0;
	logic [7:0] maker_code_field_in = 8'h00, sensor_info_in = 8'h00;
	logic [7:0] product_rev_in = 8'h00;
	logic [1:0] axis_dir_in = 2'h0, range_sel_in = 2'h0;
	logic [3:0] device_config_six_in = 4'h0, julian_month_in = 4'h0;
	logic [3:0] device_config_one_in = 4'h0;
	logic [6:0] julian_year_in = 7'h00;
	logic [4:0] julian_day_in = 5'h00;
	logic [31:0] serial_in = 32'h0;
	logic [9:0] raw_offset_in = 10'h000, average_test_deflection_in = 10'h000;
	logic frame_ready_in, frame_valid_out, busy_out, phase3_out, got;
	logic [9:0] frame_word_out, got_word;
	logic stall = 1'b0;
	int fail_count = 0;
	int n_tests = 0;
	int rx_cnt = 0;
	logic [9:0] exp_q[$];
	// clock and the two parties
	always #20 mclk_in = ~mclk_in;
	pips_phase2_sequencer #(.ASYNC_CYC(10)) uut (.*);
	pips_receiver_model rx (.mclk_in(mclk_in), .rst_in(rst_in),
		.stall_in(stall), .valid_in(frame_valid_out),
		.word_in(frame_word_out), .ready_out(frame_ready_in),
		.got_out(got), .got_word_out(got_word));
	task automatic check(input string name, input logic [9:0] seen,
		input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	// expected data nibble n of the identification table
	function automatic logic [3:0] nib(input int n);
		logic [3:0] v;
		v = 4'h0;
		case (n)
		1: return 4'h4;
		2: return 4'h2;
		3, 6: return 4'h0;
		4: return maker_code_field_in[7:4];
		5: return maker_code_field_in[3:0];
		7: return 4'h1;
		8: return {axis_dir_in, 2'b00};
		9: return 4'h7 + {2'b00, range_sel_in};
		10: return sensor_info_in[7:4];
		11: return sensor_info_in[3:0];
		12: return product_rev_in[7:4];
		13: return product_rev_in[3:0];
		14: return device_config_six_in;
		15: return julian_year_in[6:3];
		16: return {julian_year_in[2:0], julian_month_in[3]};
		17: return {julian_month_in[2:0], julian_day_in[4]};
		18: return julian_day_in[3:0];
		27: v = raw_offset_in[3:0];
		28: v = raw_offset_in[7:4];
		29: v = {average_test_deflection_in[1:0], raw_offset_in[9:8]};
		30: v = average_test_deflection_in[5:2];
		31: v = average_test_deflection_in[9:6];
		32: return extended_init_data_enable_in ? device_config_one_in : 4'h0;
		default: return serial_in[(26 - n) * 4 +: 4];
		endcase
		return (extended_init_data_enable_in && selftest_done_in) ? v : 4'h0;
	endfunction : nib
	// queue of identifier and data words in sending order
	task automatic build(input int k);
		logic [3:0] d;
		for (int n = 1; n <= (mode8_in ? 9 : 32); n++) begin
			d = nib(n);
			if (!mode8_in) repeat (k) begin
				exp_q.push_back({6'h00, 4'(n - 1)});
				exp_q.push_back({6'h00, d});
			end else for (int h = 2 * n - 2; h < 2 * n; h++) repeat (k) begin
				exp_q.push_back(10'(h));
				exp_q.push_back({8'h00, (h % 2) ? d[1:0] : d[3:2]});
			end
		end
	endtask : build
	// compare every accepted word with the model
	always @(posedge mclk_in) begin
		if (got) begin
			rx_cnt++;
			check("frame", got_word, exp_q.size() ? exp_q.pop_front() : 10'h3ff);
		end
	end
	task automatic run(input int r, input logic m8, input logic as,
		input logic ext, input logic done);
		int k;
		int total;
		logic [127:0] rnd;
		@(negedge mclk_in);
		rst_in = 1'b1;
		rnd = {$urandom, $urandom, $urandom, $urandom};
		{maker_code_field_in, sensor_info_in, product_rev_in, julian_year_in,
			julian_day_in, julian_month_in, device_config_six_in,
			device_config_one_in, serial_in, raw_offset_in,
			average_test_deflection_in} = rnd[99:0];
		{mode8_in, async_in, extended_init_data_enable_in} = {m8, as, ext};
		selftest_done_in = done;
		stall = !as;
		axis_dir_in = 2'(r % 3);
		range_sel_in = 2'(r);
		k = m8 ? (as ? 16 : 8) : (as ? 8 : 4);
		total = m8 ? (as ? 576 : 288) : (as ? 512 : 256);
		exp_q.delete();
		rx_cnt = 0;
		build(k);
		repeat (10) @(negedge mclk_in);
		rst_in = 1'b0;
		@(negedge mclk_in);
		start_in = 1'b1;
		@(negedge mclk_in);
		start_in = 1'b0;
		@(negedge mclk_in);
		check("busy", {9'h000, busy_out}, 10'h001);
		for (int i = 0; i < total && !as; i++) begin
			sync_pulse_in = 1'b1;
			@(negedge mclk_in);
			sync_pulse_in = 1'b0;
			for (int w = 0; w < 60 && rx_cnt == i; w++)
				@(negedge mclk_in);
			ce_in = (i % 2 == 0); // odd gaps freeze the design one cycle
			@(negedge mclk_in);
			ce_in = 1'b1;
		end
		for (int w = 0; w < 9000 && !phase3_out; w++)
			@(negedge mclk_in);
		check("count", 10'(rx_cnt), 10'(total));
		check("handover", {9'h000, phase3_out}, 10'h001);
		check("idle", {9'h000, busy_out}, 10'h000);
	endtask : run
	initial begin
		void'($urandom(32'h3a18aeab));
		run(0, 1'b0, 1'b0, 1'b1, 1'b1);
		run(1, 1'b0, 1'b1, 1'b1, 1'b0);
		run(2, 1'b1, 1'b1, 1'b1, 1'b1);
		run(3, 1'b0, 1'b0, 1'b0, 1'b1);
		run(4, 1'b1, 1'b0, 1'b1, 1'b1);
		print_verdict();
	end
	// cut a hang short
	initial begin
		repeat (60000) @(posedge mclk_in);
		fail_count++;
		print_verdict();
	end
endmodule : pips_phase2_sequencer_tb
`default_nettype wire
